// >>> src/pcg_top.sv
// Clock generator control: crystal path, loop dividers, lock detector and base clock selector.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`include "pcg_consts.svh"
// How it works
// - Crystal path runs only while the oscillator enable input is high.
// - Crystal clock follows the crystal pin edge for edge; duty not balanced.
// - Loop reference clock is a buffered copy of the crystal clock.
// - Base clock is crystal or loop clock halved, chosen by software.
// - Reference clock passes a modulo divider by R for comparison.
// - VCO clock is divided by two to the P, then by N.
// - Phase detector emits up or down pulses sized by phase error.
// - Lock detector compares feedback and reference frequencies for mode and lock.
// - Tracking indicator reads clear while filter is in acquisition.
// - Filter tracks whenever not acquiring or when the indicator is set.
// - In automatic mode the detector switches filter modes itself.
// - In automatic mode the indicator is read-only and shows filter mode.
// - Indicator sets inside tracking tolerance, clears outside untracking tolerance.
// - Lock flag sets inside lock tolerance, clears outside unlock tolerance.
// - With enable set, every lock flag toggle requests an interrupt.
// - VCO clock is also the reference clock for the USB function.
// - On a source change the base clock holds for three edges each.
// - Refuse VCO select with loop off, loop off when selected, both together.
// - A zero reference divider or multiplier acts as one.
// - Lock change drives a dedicated interrupt output from the detector.
module pcg_top #(
  parameter int N_W = 8,
  parameter int R_W = 4,
  parameter int WIN_REFS = `PCG_WIN_REFS
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic OSCILLATOR_ENABLE_IN,
  input wire logic CRYSTAL_IN_PIN,
  input wire logic VCO_CLOCK_IN,
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic CRYSTAL_OUT_PIN,
  output logic CRYSTAL_CLOCK,
  output logic LOOP_REFERENCE_CLOCK,
  output logic BASE_CLOCK_OUT,
  output logic USB_REFERENCE_CLOCK,
  output logic LOOP_ENABLE,
  output logic PUMP_UP,
  output logic PUMP_DOWN,
  output logic TRACK_MODE,
  output logic LOCK,
  output logic LOCK_CHANGE_IRQ
);
  localparam logic [7:0] WIN8 = 8'(WIN_REFS);
  localparam logic [7:0] WIN_LAST = 8'(WIN_REFS - 1);

  if (WIN_REFS < 2 || WIN_REFS > 120 || N_W > 8 || N_W < 1 || R_W > 8 || R_W < 1)
  begin : g_bad_param
    $error("pcg_top parameters out of range");
  end

  pcg_edge_if xtal_e ();
  pcg_edge_if vco_e ();
  logic osc_meta;
  logic osc_en;
  logic base_source_select;
  logic loop_on;
  logic [1:0] prescale;
  logic lock_change_irq_enable;
  logic auto_bw;
  logic [N_W-1:0] mult;
  logic [R_W-1:0] rdiv;
  logic xtal_rise;
  logic ref_p;
  logic pre_p;
  logic fb_p;
  logic wr_ctrl;
  logic ch_sel;
  logic ch_on;
  pcg_pkg::pcg_sw_state_t sw_state;
  logic active_src;
  logic [1:0] sw_cnt;
  logic src_rise;
  logic [7:0] win_cnt;
  logic [7:0] fb_cnt;
  logic win_end;
  logic [7:0] err;
  logic next_lock;
  logic next_track;

  // Crystal and VCO pins come from outside this clock domain.
  pcg_edge u_xtal_edge (
    .clk(CLK),
    .rst(RESET),
    .pin(CRYSTAL_IN_PIN),
    .e(xtal_e.src)
  );
  pcg_edge u_vco_edge (
    .clk(CLK),
    .rst(RESET),
    .pin(VCO_CLOCK_IN),
    .e(vco_e.src)
  );

  // Enable from the integration unit is a level from another domain.
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      osc_meta <= 1'h0;
      osc_en <= 1'h0;
    end
    else
    begin
      osc_meta <= OSCILLATOR_ENABLE_IN;
      osc_en <= osc_meta;
    end
  end

  assign xtal_rise = xtal_e.rise & osc_en;

  // Crystal path, USB reference and loop enable outputs; the amplifier output is the inverted input while enabled.
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      CRYSTAL_OUT_PIN <= 1'h0;
      CRYSTAL_CLOCK <= 1'h0;
      LOOP_REFERENCE_CLOCK <= 1'h0;
      USB_REFERENCE_CLOCK <= 1'h0;
      LOOP_ENABLE <= 1'h0;
    end
    else
    begin
      CRYSTAL_OUT_PIN <= osc_en & ~xtal_e.level;
      CRYSTAL_CLOCK <= osc_en & xtal_e.level;
      LOOP_REFERENCE_CLOCK <= CRYSTAL_CLOCK;
      USB_REFERENCE_CLOCK <= loop_on & vco_e.level;
      LOOP_ENABLE <= loop_on & osc_en;
    end
  end

  pcg_div #(.W(R_W)) u_ref_div (
    .clk(CLK),
    .rst(RESET),
    .clr(!loop_on),
    .en(xtal_rise),
    .modulo(rdiv),
    .pulse(ref_p)
  );
  pcg_div #(.W(4)) u_pre_div (
    .clk(CLK),
    .rst(RESET),
    .clr(!loop_on),
    .en(vco_e.rise & loop_on),
    .modulo(4'h1 << prescale),
    .pulse(pre_p)
  );
  pcg_div #(.W(N_W)) u_fb_div (
    .clk(CLK),
    .rst(RESET),
    .clr(!loop_on),
    .en(pre_p),
    .modulo(mult),
    .pulse(fb_p)
  );

  assign wr_ctrl = WR && (ADDR == `PCG_ADR_CTRL);
  assign ch_sel = WDATA[`PCG_CTRL_SEL] != base_source_select;
  assign ch_on = WDATA[`PCG_CTRL_ON] != loop_on;

  // Control register; selector and loop switch guard each other.
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      base_source_select <= 1'h0;
      loop_on <= 1'h0;
      prescale <= `PCG_RST_PRE;
      lock_change_irq_enable <= 1'h0;
    end
    else if (wr_ctrl)
    begin
      prescale <= WDATA[`PCG_CTRL_PRE_HI:`PCG_CTRL_PRE_LO];
      lock_change_irq_enable <= WDATA[`PCG_CTRL_IE];
      if (ch_sel && !ch_on && loop_on)
        base_source_select <= WDATA[`PCG_CTRL_SEL];
      if (ch_on && !ch_sel && !base_source_select)
        loop_on <= WDATA[`PCG_CTRL_ON];
    end
  end

  // Divider and mode registers.
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      auto_bw <= `PCG_RST_AUTO;
      mult <= N_W'(`PCG_RST_MULT);
      rdiv <= R_W'(`PCG_RST_RDIV);
    end
    else if (WR)
    begin
      if (ADDR == `PCG_ADR_BW)
        auto_bw <= WDATA[`PCG_BW_AUTO];
      if (ADDR == `PCG_ADR_MULT)
        mult <= WDATA[N_W-1:0];
      if (ADDR == `PCG_ADR_RDIV)
        rdiv <= WDATA[R_W-1:0];
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      RDATA <= 8'h00;
    else if (!RD)
      RDATA <= 8'h00;
    else
      case (ADDR)
        `PCG_ADR_CTRL: RDATA <= {3'h0, lock_change_irq_enable, prescale, loop_on,
                                 base_source_select};
        `PCG_ADR_BW: RDATA <= {5'h00, LOCK, TRACK_MODE, auto_bw};
        `PCG_ADR_MULT: RDATA <= 8'(mult);
        default: RDATA <= 8'(rdiv);
      endcase
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      PUMP_UP <= 1'h0;
      PUMP_DOWN <= 1'h0;
    end
    else if (!loop_on || ((PUMP_UP || ref_p) && (PUMP_DOWN || fb_p)))
    begin
      PUMP_UP <= 1'h0;
      PUMP_DOWN <= 1'h0;
    end
    else
    begin
      PUMP_UP <= PUMP_UP | ref_p;
      PUMP_DOWN <= PUMP_DOWN | fb_p;
    end
  end

  assign win_end = ref_p && (win_cnt == WIN_LAST);
  assign err = (fb_cnt >= WIN8) ? fb_cnt - WIN8 : WIN8 - fb_cnt;

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      win_cnt <= 8'h00;
      fb_cnt <= 8'h00;
    end
    else if (!loop_on)
    begin
      win_cnt <= 8'h00;
      fb_cnt <= 8'h00;
    end
    else
    begin
      if (ref_p)
        win_cnt <= win_end ? 8'h00 : win_cnt + 8'h01;
      if (win_end)
        fb_cnt <= {7'h00, fb_p};
      else if (fb_p && fb_cnt != 8'hFF)
        fb_cnt <= fb_cnt + 8'h01;
    end
  end

  // mode and lock from one comparison
  always_comb
  begin
    next_lock = LOCK;
    next_track = TRACK_MODE;
    if (!loop_on)
    begin
      next_lock = 1'h0;
      next_track = 1'h0;
    end
    else
    begin
      if (win_end)
        next_lock = LOCK ? (err <= `PCG_LOCK_OUT) : (err <= `PCG_LOCK_IN);
      if (auto_bw && win_end)
        next_track = TRACK_MODE ? (err <= `PCG_TRK_OUT) : (err <= `PCG_TRK_IN);
      else if (!auto_bw && WR && ADDR == `PCG_ADR_BW)
        next_track = WDATA[`PCG_BW_TRK];
    end
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      TRACK_MODE <= 1'h0;
      LOCK <= 1'h0;
      LOCK_CHANGE_IRQ <= 1'h0;
    end
    else
    begin
      TRACK_MODE <= next_track;
      LOCK <= next_lock;
      LOCK_CHANGE_IRQ <= lock_change_irq_enable && (next_lock != LOCK);
    end
  end

  assign src_rise = active_src ? pre_p : xtal_rise;

  // Base clock selector; the clock holds still while old and new sources settle.
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      sw_state <= pcg_pkg::SW_RUN;
      active_src <= 1'h0;
      sw_cnt <= 2'h0;
      BASE_CLOCK_OUT <= 1'h0;
    end
    else
      case (sw_state)
        pcg_pkg::SW_RUN:
          if (active_src != base_source_select)
          begin
            sw_state <= pcg_pkg::SW_WAIT_OLD;
            sw_cnt <= 2'h0;
          end
          else if (src_rise)
            BASE_CLOCK_OUT <= ~BASE_CLOCK_OUT;
        pcg_pkg::SW_WAIT_OLD:
          if (src_rise)
          begin
            if (sw_cnt == `PCG_SW_EDGES - 2'h1)
            begin
              active_src <= ~active_src;
              sw_cnt <= 2'h0;
              sw_state <= pcg_pkg::SW_WAIT_NEW;
            end
            else
              sw_cnt <= sw_cnt + 2'h1;
          end
        pcg_pkg::SW_WAIT_NEW:
          if (src_rise)
          begin
            if (sw_cnt == `PCG_SW_EDGES - 2'h1)
            begin
              sw_cnt <= 2'h0;
              sw_state <= pcg_pkg::SW_RUN;
            end
            else
              sw_cnt <= sw_cnt + 2'h1;
          end
        default: sw_state <= pcg_pkg::SW_RUN;
      endcase
  end

  sequence s_switch_start;
    sw_state == pcg_pkg::SW_RUN && active_src != base_source_select;
  endsequence
  sequence s_held;
    sw_state != pcg_pkg::SW_RUN;
  endsequence

  a_osc_gated: assert property (@(posedge CLK) disable iff (RESET)
    !osc_en |=> !CRYSTAL_CLOCK && !CRYSTAL_OUT_PIN)
    else $error("crystal path ran without enable");
  a_ref_copy: assert property (@(posedge CLK) disable iff (RESET)
    ##1 LOOP_REFERENCE_CLOCK == $past(CRYSTAL_CLOCK))
    else $error("loop reference is not a copy of the crystal clock");
  a_switch_hold: assert property (@(posedge CLK) disable iff (RESET)
    s_switch_start |=> s_held ##0 $stable(BASE_CLOCK_OUT))
    else $error("base clock moved at source change");
  a_base_toggle: assert property (@(posedge CLK) disable iff (RESET)
    (sw_state == pcg_pkg::SW_RUN && active_src == base_source_select && src_rise)
    |=> BASE_CLOCK_OUT != $past(BASE_CLOCK_OUT))
    else $error("base clock missed a source edge");
  a_sel_refused: assert property (@(posedge CLK) disable iff (RESET)
    (wr_ctrl && ch_sel && ch_on) |=> $stable(base_source_select) && $stable(loop_on))
    else $error("selector and loop changed in one write");
  a_lock_irq: assert property (@(posedge CLK) disable iff (RESET)
    ($changed(LOCK) && $past(lock_change_irq_enable)) |-> LOCK_CHANGE_IRQ)
    else $error("lock toggle without interrupt request");
  a_auto_ro: assert property (@(posedge CLK) disable iff (RESET)
    (auto_bw && loop_on && WR && ADDR == `PCG_ADR_BW && !win_end && WDATA[0])
    |=> TRACK_MODE == $past(TRACK_MODE))
    else $error("write changed the indicator in automatic mode");
  a_pump_excl: assert property (@(posedge CLK) disable iff (RESET)
    !(PUMP_UP && PUMP_DOWN))
    else $error("both correction pulses active");
  a_lock_off: assert property (@(posedge CLK) disable iff (RESET)
    !loop_on |=> !LOCK && !TRACK_MODE)
    else $error("lock held with loop off");
endmodule

// >>> src/pcg_consts.svh
// Offsets, field positions, reset values and timing counts of the clock generator control.
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH
`define PCG_CLK_PERIOD_NS 100
`define PCG_ADR_CTRL 2'h0
`define PCG_ADR_BW 2'h1
`define PCG_ADR_MULT 2'h2
`define PCG_ADR_RDIV 2'h3
`define PCG_CTRL_SEL 0
`define PCG_CTRL_ON 1
`define PCG_CTRL_PRE_LO 2
`define PCG_CTRL_PRE_HI 3
`define PCG_CTRL_IE 4
`define PCG_BW_AUTO 0
`define PCG_BW_TRK 1
`define PCG_BW_LOCK 2
`define PCG_RST_PRE 2'h1
`define PCG_RST_MULT 8'h04
`define PCG_RST_RDIV 4'h1
`define PCG_RST_AUTO 1'h1
`define PCG_SW_EDGES 2'h3
`define PCG_WIN_REFS 16
`define PCG_TRK_IN 8'h02
`define PCG_TRK_OUT 8'h04
`define PCG_LOCK_IN 8'h00
`define PCG_LOCK_OUT 8'h01
`endif

// >>> src/pcg_pkg.sv
// Types shared by the clock generator control.
package pcg_pkg;
  typedef enum logic [1:0] {
    SW_RUN = 2'h0,
    SW_WAIT_OLD = 2'h1,
    SW_WAIT_NEW = 2'h2
  } pcg_sw_state_t;
endpackage

// >>> src/pcg_edge_if.sv
// Level and rising-edge pulse of one sampled external clock.
`timescale 1ns/100ps
interface pcg_edge_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface

// >>> src/pcg_edge.sv
// Synchroniser and rising-edge detector for one external clock pin.
`timescale 1ns/100ps
module pcg_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  pcg_edge_if.src e
);
  logic meta;
  logic s2;
  logic s3;

  // Two flops before use; the third flop feeds only the edge detector.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= 1'h0;
      s2 <= 1'h0;
      s3 <= 1'h0;
    end
    else
    begin
      meta <= pin;
      s2 <= meta;
      s3 <= s2;
    end
  end

  assign e.level = s2;
  assign e.rise = s2 & ~s3;
endmodule

// >>> src/pcg_div.sv
// Modulo pulse divider: one output pulse for every modulo input pulses.
`timescale 1ns/100ps
module pcg_div #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic en,
  input wire logic [W-1:0] modulo,
  output logic pulse
);
  logic [W-1:0] cnt;
  logic [W-1:0] last;

  if (W < 1 || W > 16)
  begin : g_bad_width
    $error("pcg_div width out of range");
  end

  assign last = (modulo == '0) ? '0 : modulo - W'(1);
  assign pulse = en && !clr && (cnt >= last);

  // The count restarts on the output pulse; the at-or-above compare keeps a shrinking modulo from hanging.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt <= '0;
    else if (clr || pulse)
      cnt <= '0;
    else if (en)
      cnt <= cnt + W'(1);
  end

  a_div_zero_one: assert property (@(posedge clk) disable iff (rst)
    (en && !clr && modulo <= W'(1)) |-> pulse)
    else $error("divider of zero or one did not pass every pulse");
  a_div_period: assert property (@(posedge clk) disable iff (rst)
    (pulse && modulo > W'(1)) |=> (!pulse || modulo <= W'(1)))
    else $error("divider pulsed twice in a row");
endmodule

// >>> testbench/pcg_far_model.sv
// Far-side model: crystal and VCO waveforms and the half-rate bus clock of the integration unit.
`timescale 1ns/100ps
module pcg_far_model #(
  parameter int XTAL_HALF_NS = 400
) (
  input wire logic base_clock,
  input wire logic loop_enable,
  input wire logic [15:0] vco_half_ns,
  output logic crystal_pin,
  output logic vco_pin,
  output logic bus_clock
);
  // The crystal runs free, so any gating has to come from the device itself.
  initial
  begin
    crystal_pin = 1'h0;
    #30;
    forever #(XTAL_HALF_NS) crystal_pin = ~crystal_pin;
  end
  // The VCO swings only while the loop is powered; the offset keeps edges off the clock edge.
  initial
  begin
    vco_pin = 1'h0;
    #70;
    forever
    begin
      if (loop_enable)
        #(vco_half_ns) vco_pin = ~vco_pin;
      else
      begin
        vco_pin = 1'h0;
        @(posedge loop_enable);
        #7;
      end
    end
  end
  // The integration unit divides the base clock by two for its bus clock.
  // Half-rate bus clock.
  initial bus_clock = 1'h0;
  always @(posedge base_clock) bus_clock <= ~bus_clock;
endmodule

// >>> testbench/tb_top.sv
// Testbench: register rows, crystal path, lock detection, interrupts and base clock switching.
`timescale 1ns/100ps
`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end
module tb_top;
  typedef struct {logic is_wr; logic [1:0] adr; logic [7:0] dat; logic [7:0] exp;} pcg_row_t;
  logic clk, reset, osc_en, wr, rd, prev_cc;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, d;
  logic crystal_pin, vco_pin, bus_clock, crystal_out_pin, crystal_clock, loop_ref;
  logic base_clk, usb_clk, loop_en, pump_up, pump_dn, track, lock, irq;
  logic [15:0] vco_half;
  int err_total, n_compared, n_xtal, n_xpin, n_base, n_usb, n_vco, n_up, n_dn, n_irq, irq0;
  int n_bus;
  // Reset values, refused control writes, field widths, read-only and manual tracking bit.
  pcg_row_t rows [17] = '{
    '{1'h0, 2'h0, 8'h00, 8'h04}, '{1'h0, 2'h1, 8'h00, 8'h01},
    '{1'h0, 2'h2, 8'h00, 8'h04}, '{1'h0, 2'h3, 8'h00, 8'h01},
    '{1'h1, 2'h0, 8'h01, 8'h00}, '{1'h1, 2'h0, 8'h03, 8'h00},
    '{1'h1, 2'h0, 8'h02, 8'h02}, '{1'h1, 2'h0, 8'h03, 8'h03},
    '{1'h1, 2'h0, 8'h00, 8'h03}, '{1'h1, 2'h0, 8'h01, 8'h03},
    '{1'h1, 2'h0, 8'h02, 8'h02}, '{1'h1, 2'h2, 8'h02, 8'h02},
    '{1'h1, 2'h3, 8'hF1, 8'h01}, '{1'h1, 2'h1, 8'h03, 8'h01},
    '{1'h1, 2'h1, 8'h00, 8'h00}, '{1'h1, 2'h1, 8'h02, 8'h02},
    '{1'h1, 2'h1, 8'h01, 8'h01}};

  pcg_top #(.WIN_REFS(8)) u_dut (.CLK(clk), .RESET(reset), .OSCILLATOR_ENABLE_IN(osc_en),
    .CRYSTAL_IN_PIN(crystal_pin), .VCO_CLOCK_IN(vco_pin), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .CRYSTAL_OUT_PIN(crystal_out_pin),
    .CRYSTAL_CLOCK(crystal_clock), .LOOP_REFERENCE_CLOCK(loop_ref),
    .BASE_CLOCK_OUT(base_clk), .USB_REFERENCE_CLOCK(usb_clk), .LOOP_ENABLE(loop_en),
    .PUMP_UP(pump_up), .PUMP_DOWN(pump_dn), .TRACK_MODE(track), .LOCK(lock),
    .LOCK_CHANGE_IRQ(irq));
  pcg_far_model u_far (.base_clock(base_clk), .loop_enable(loop_en), .vco_half_ns(vco_half),
    .crystal_pin(crystal_pin), .vco_pin(vco_pin), .bus_clock(bus_clock));

  // Clock of 100 ns period.
  initial clk = 1'h0;
  always #50 clk = ~clk;
  // Edge counters over a measuring span.
  always @(posedge crystal_clock) n_xtal++;
  always @(posedge crystal_pin) n_xpin++;
  always @(posedge base_clk) n_base++;
  always @(posedge usb_clk) n_usb++;
  always @(posedge vco_pin) n_vco++;
  always @(posedge bus_clock) n_bus++;
  // Level counters sampled on the system clock, plus the buffered reference check.
  always @(posedge clk)
  begin
    if (pump_up) n_up++;
    if (pump_dn) n_dn++;
    if (irq) n_irq++;
    if (!reset) `CHK(loop_ref, prev_cc) // Buffered copy.
    prev_cc <= crystal_clock;
  end

  function automatic logic near(input int a, input int b);
    return (a - b <= 1) && (b - a <= 1);
  endfunction
  task wr_reg(input logic [1:0] a, input logic [7:0] dt);
    @(posedge clk);
    addr <= a;
    wdata <= dt;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task rd_reg(input logic [1:0] a, output logic [7:0] dt);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    dt = rdata;
  endtask
  // Counters are cleared off the clock edge so no counting process races the clear.
  task measure(input int cyc);
    @(negedge clk);
    {n_xtal, n_xpin, n_base, n_usb, n_vco, n_up, n_dn, n_bus} = '0;
    repeat (cyc) @(negedge clk);
  endtask
  task set_vco(input logic [15:0] h);
    @(posedge clk);
    vco_half <= h;
    repeat (600) @(posedge clk);
  endtask
  task wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog sized well beyond the roughly 4300 cycles the sequence needs.
  initial
  begin
    #2000000;
    err_total++;
    wrap_up;
  end

  // Main sequence.
  initial
  begin
    {reset, osc_en, wr, rd, addr, wdata, prev_cc} = {1'h1, 1'h0, 1'h0, 1'h0, 2'h0, 8'h00, 1'h0};
    vco_half = 16'h03E8;
    repeat (5) @(posedge clk);
    `CHK({rdata, base_clk, lock, irq}, 11'h000) // Quiet in reset.
    reset <= 1'h0;
    measure(64);
    `CHK(n_xtal, 0) // Gated while disabled.
    `CHK(crystal_out_pin, 1'h0) // Amplifier idle.
    @(posedge clk);
    osc_en <= 1'h1;
    foreach (rows[i])
    begin
      if (rows[i].is_wr)
        wr_reg(rows[i].adr, rows[i].dat);
      rd_reg(rows[i].adr, d);
      `CHK(d, rows[i].exp) // Register row.
    end
    wr_reg(2'h0, 8'h12);
    irq0 = n_irq;
    // The rows leave source switches pending; a slow VCO makes them take many cycles.
    repeat (300) @(posedge clk);
    measure(256);
    `CHK(loop_en, 1'h1) // Loop powered with enable.
    `CHK(crystal_out_pin, ~crystal_clock) // Amplifier inverts.
    `CHK(near(n_base, n_xtal / 2), 1'h1) // Crystal halved.
    `CHK(near(n_xtal, n_xpin), 1'h1) // Crystal rate.
    `CHK(n_up > n_dn, 1'h1) // Slow VCO pumps up.
    `CHK({lock, track}, 2'h0) // Far off frequency.
    set_vco(16'h00C8);
    `CHK({lock, track}, 2'h3) // Lock and tracking set.
    rd_reg(2'h1, d);
    `CHK(d, 8'h07) // Status readback.
    `CHK(n_irq - irq0, 1) // Lock entry request.
    measure(256);
    `CHK(near(n_usb, n_vco), 1'h1) // USB clock rate.
    // The VCO source is chosen once lock is seen.
    wr_reg(2'h0, 8'h13);
    repeat (100) @(posedge clk);
    measure(256);
    `CHK(near(n_base, n_vco / 2), 1'h1) // Switched to loop clock.
    `CHK(near(n_bus, n_base / 2), 1'h1) // Bus clock at half rate.
    set_vco(16'h03E8);
    `CHK({lock, track}, 2'h0) // Lock and tracking lost.
    `CHK(n_irq - irq0, 2) // Lock exit request.
    // Lost lock on the VCO source: fall back to the crystal.
    wr_reg(2'h0, 8'h12);
    rd_reg(2'h0, d);
    `CHK(d, 8'h12) // Deselect allowed.
    wr_reg(2'h0, 8'h02);
    set_vco(16'h00C8);
    `CHK(lock, 1'h1) // Relocks unaided.
    `CHK(n_irq - irq0, 2) // Masked request.
    wr_reg(2'h2, 8'h00);
    wr_reg(2'h0, 8'h06);
    repeat (600) @(posedge clk);
    `CHK(lock, 1'h1) // Zero multiplier as one.
    wr_reg(2'h0, 8'h0A);
    repeat (600) @(posedge clk);
    `CHK(lock, 1'h0) // Prescale changes feedback.
    @(posedge clk);
    reset <= 1'h1;
    repeat (5) @(posedge clk);
    `CHK({lock, irq, base_clk, track, loop_en}, 5'h00) // Mid-run reset clears.
    reset <= 1'h0;
    rd_reg(2'h0, d);
    `CHK(d, 8'h04) // Control back to reset value.
    wrap_up;
  end
endmodule
